// *** include/srf_pkg.sv ***
// Purpose: Shared constants and types for the serial frame engine.
// Assumes: 100 MHz system clock, 32-bit register bus with byte addresses.
// Notes:   Timing figures are kept in their printed units and converted.

`default_nettype none

package srf_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 100_000_000;
	localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
	localparam int T_GAP_FAST_US = 750;
	localparam int T_SIL_FAST_US = 1750;
	localparam int T_TMO_S       = 1;
	localparam int GAP_FAST_CYC  = T_GAP_FAST_US * CLK_MHZ;
	localparam int SIL_FAST_CYC  = T_SIL_FAST_US * CLK_MHZ;
	localparam int SEC_CYC       = T_TMO_S * CLK_HZ;
	localparam int SLOW_BAUD     = 19200;
	localparam logic [15:0] FAST_DIV_LIMIT = 16'(CLK_HZ / SLOW_BAUD);
	localparam logic [31:0] GAP_HALF_BITS  = 32'h0000_0021;
	localparam logic [31:0] SIL_HALF_BITS  = 32'h0000_004D;
	localparam logic [3:0]  CHAR_BITS_BIN  = 4'hB;
	localparam logic [3:0]  CHAR_BITS_TXT  = 4'hA;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_OWN_ADDR = 12'h004;
	localparam logic [11:0] REG_BAUD_DIV = 12'h008;
	localparam logic [11:0] REG_LF_CHAR  = 12'h00C;
	localparam logic [11:0] REG_TMO_SEC  = 12'h010;
	localparam logic [11:0] REG_STATUS   = 12'h014;
	localparam logic [11:0] REG_TX_LEN   = 12'h018;
	localparam logic [11:0] REG_RX_LEN   = 12'h01C;
	localparam logic [11:0] REG_CMD      = 12'h020;
	localparam logic [1:0]  WIN_REGS     = 2'h0;
	localparam logic [1:0]  WIN_RX_BUF   = 2'h1;
	localparam logic [1:0]  WIN_TX_BUF   = 2'h2;

	// ----------------------------------------------------------------
	// Fields, reset values and characters
	// ----------------------------------------------------------------
	localparam logic [1:0]  PAR_EVEN     = 2'h0;
	localparam logic [1:0]  PAR_ODD      = 2'h1;
	localparam logic [1:0]  PAR_NONE     = 2'h2;
	localparam int          ST_FRAME_OK  = 0;
	localparam int          ST_CHECK_ERR = 1;
	localparam int          ST_CHAR_ERR  = 2;
	localparam int          ST_INCOMPL   = 3;
	localparam int          ST_TIMEOUT   = 4;
	localparam int          ST_TX_DONE   = 5;
	localparam int          ST_DROPPED   = 6;
	localparam int          CMD_SEND     = 0;
	localparam logic [7:0]  OWN_ADDR_RST = 8'h01;
	localparam logic [7:0]  LF_RST       = 8'h0A;
	localparam logic [7:0]  TMO_RST      = 8'h01;
	localparam logic [15:0] DIV_RST      = FAST_DIV_LIMIT;
	localparam logic [7:0]  CH_COLON     = 8'h3A;
	localparam logic [7:0]  CH_CR        = 8'h0D;
	localparam logic [7:0]  ADDR_BCAST   = 8'h00;
	localparam logic [15:0] CRC_INIT     = 16'hFFFF;
	localparam logic [15:0] CRC_POLY     = 16'hA001;
	localparam logic [8:0]  RX_MAX_LEN   = 9'h100;
	localparam logic [8:0]  TX_MAX_LEN   = 9'h0FE;
	localparam logic [8:0]  BIN_MIN_LEN  = 9'h004;
	localparam logic [8:0]  TXT_MIN_LEN  = 9'h003;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       early;
		logic [1:0] par;
		logic       text;
	} srf_cfg_t;

	localparam srf_cfg_t CFG_RST = '0;

	typedef enum logic [1:0] {LN_INIT, LN_IDLE, LN_RX, LN_TX} srf_link_t;
	typedef enum logic [2:0] {
		TP_SOF, TP_DATA, TP_CK0, TP_CK1, TP_CR, TP_LF, TP_END
	} srf_txph_t;

endpackage : srf_pkg

`default_nettype wire

// *** design/srf_framer.sv ***
// Purpose: Serial line frame engine for silence-framed binary frames and
//          colon/CRLF framed hex text frames, with an Avalon-MM slave.
// Assumes: line_i is asynchronous; idle line is high.
// Notes:   Frames move through two 256-byte buffers mapped on the bus.
//
// Summary of operation
// - Binary mode starts in init state; idle only after 3.5 char silence.
// - In idle, any received binary character opens a new frame.
// - Binary frame ends after 3.5 character times of silence.
// - At frame end verify check value first, then drop foreign addresses.
// - Optional early address decode skips checking foreign frames.
// - Transmitter appends 16-bit check, low byte first, high byte last.
// - Receiver recomputes 16-bit check; mismatch raises an error.
// - Check register presets to all ones; only data bits feed it.
// - Per byte: XOR in, eight right shifts, conditional constant XOR.
// - Text mode sends each byte as two upper-case hex characters.
// - Text characters: start, seven data LSB first, parity, stop.
// - Parity even, odd or none; even is default; none adds a stop.
// - Text frame opens with colon and closes with CR then LF.
// - The closing LF value is a software setting.
// - Receiver hunts for colon then decodes until the closing pair.
// - Text gap over one second, or configured time, is an error.
// - Text frame: address, function, data, check; at most 513 chars (receiver accepts up to 256 bytes, 515 chars).
// - A colon inside a text frame discards it and restarts reception.
// - Text frame end: verify sum check, then drop foreign addresses.
// - Sum check is two's complement of byte sum, delimiters excluded.
// - Sum check sent as two hex chars before CRLF; mismatch is error.
// - Binary gap over 1.5 char times marks the frame incomplete.
// - Above 19200 baud use fixed 750 us and 1.75 ms timers.
// - Binary characters carry eight data bits, LSB first, parity, stop.
// - Binary frames never exceed 256 bytes.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.

`timescale 1ns/1ns
`default_nettype none

module srf_framer
	import srf_pkg::*;
#(
	parameter int GAP_CYC = GAP_FAST_CYC,
	parameter int SIL_CYC = SIL_FAST_CYC,
	parameter int TMO_CYC = SEC_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        line_i,
	output logic             line_o,
	output logic             line_oe_n
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc_step(input logic [15:0] c,
	                                         input logic [7:0]  b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ({1'b0, r[15:1]} ^ CRC_POLY) : {1'b0, r[15:1]};
		end
		return r;
	endfunction : crc_step

	function automatic logic par_bit(input logic [7:0] d,
	                                 input logic [1:0] p);
		return (p == PAR_ODD) ? ~^d : ^d;
	endfunction : par_bit

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hex_char

	function automatic logic [10:0] tx_frame(input logic [7:0] c,
	                                         input logic       txt,
	                                         input logic [1:0] p);
		logic pb;
		pb = (p == PAR_NONE) ? 1'b1 : par_bit(txt ? {1'b0, c[6:0]} : c, p);
		return txt ? {2'b11, pb, c[6:0], 1'b0} : {1'b1, pb, c, 1'b0};
	endfunction : tx_frame

	// ----------------------------------------------------------------
	// State declarations
	// ----------------------------------------------------------------
	srf_cfg_t    cfg_q, cfg_d;
	logic [7:0]  own_q, own_d, lf_q, lf_d, tmo_q, tmo_d;
	logic [15:0] div_q, div_d;
	logic [6:0]  stat_q, stat_d, st_set;
	logic [8:0]  txlen_q, txlen_d, rxlen_q, rxlen_d;
	logic        tx_req_q, tx_req_d, tx_take, ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ln_s1_q, ln_s2_q;
	logic        rc_busy_q, rc_busy_d, ch_v_q, ch_v_d, ch_err_q, ch_err_d;
	logic [15:0] rc_cnt_q, rc_cnt_d;
	logic [3:0]  rc_idx_q, rc_idx_d;
	logic [10:0] rc_sh_q, rc_sh_d;
	logic [7:0]  ch_q, ch_d;
	logic [39:0] sil_q, sil_d, t15, t35, tmo_lim;
	srf_link_t   ln_q, ln_d;
	srf_txph_t   tp_q, tp_d;
	logic [8:0]  len_q, len_d, tidx_q, tidx_d;
	logic [15:0] crc_q, crc_d, tx_cnt_q, tx_cnt_d;
	logic [7:0]  lrc_q, lrc_d, adr_q, adr_d;
	logic [3:0]  nib_q, nib_d, tx_n_q, tx_n_d;
	logic        half_q, half_d, cr_q, cr_d, bad_q, bad_d, skip_q, skip_d;
	logic        gap_q, gap_d, tx_busy_q, tx_busy_d, oe_n_q, oe_n_d;
	logic [10:0] tx_sh_q, tx_sh_d;
	logic        rx_we, rx_open, byte_v, fin, chk_ok, tgo, fast;
	logic [7:0]  rx_wd, byte_b, tchr, tb, ck;
	logic [4:0]  hv;
	logic [7:0]  rx_mem [0:255];
	logic [7:0]  tx_mem [0:255];
	logic        req, wr_ok, rd_go;

	// Own address or broadcast counts as addressed to this node.
	function automatic logic mine(input logic [7:0] a);
		return (a == own_q) || (a == ADDR_BCAST);
	endfunction : mine

	// ----------------------------------------------------------------
	// Line synchroniser
	// ----------------------------------------------------------------
	// Two flops before anything looks at the asynchronous line.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ln_s1_q <= 1'b1;
			ln_s2_q <= 1'b1;
		end else begin
			ln_s1_q <= line_i;
			ln_s2_q <= ln_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Character receiver and silence timer
	// ----------------------------------------------------------------
	// Samples mid-bit; a start bit that is high at its middle is a glitch.
	always_comb begin
		rc_busy_d = rc_busy_q;
		rc_cnt_d  = rc_cnt_q;
		rc_idx_d  = rc_idx_q;
		rc_sh_d   = rc_sh_q;
		ch_v_d    = 1'b0;
		ch_d      = ch_q;
		ch_err_d  = ch_err_q;
		sil_d     = (rc_busy_q || !ln_s2_q || ln_q == LN_TX) ? '0 :
		            ((&sil_q) ? sil_q : sil_q + 40'h1);
		if (!rc_busy_q) begin
			if (!ln_s2_q) begin
				rc_busy_d = 1'b1;
				rc_cnt_d  = {1'b0, div_q[15:1]};
				rc_idx_d  = 4'h0;
			end
		end else if (rc_cnt_q != 16'h0) begin
			rc_cnt_d = rc_cnt_q - 16'h1;
		end else begin
			rc_cnt_d          = div_q - 16'h1;
			rc_sh_d[rc_idx_q] = ln_s2_q;
			rc_idx_d          = rc_idx_q + 4'h1;
			if (rc_idx_q == 4'h0 && ln_s2_q) begin
				rc_busy_d = 1'b0;
			end else if (rc_idx_q == (cfg_q.text ? 4'h9 : 4'hA)) begin
				rc_busy_d = 1'b0;
				ch_v_d    = 1'b1;
				ch_d      = cfg_q.text ? {1'b0, rc_sh_q[7:1]} : rc_sh_q[8:1];
				// Parity, second stop or stop bit wrong flags the character.
				ch_err_d  = !ln_s2_q ||
				            ((cfg_q.par == PAR_NONE) ?
				             !rc_sh_q[cfg_q.text ? 8 : 9] :
				             (rc_sh_q[cfg_q.text ? 8 : 9] != par_bit(ch_d,
				              cfg_q.par)));
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rc_busy_q <= 1'b0;
			rc_cnt_q  <= '0;
			rc_idx_q  <= '0;
			rc_sh_q   <= '0;
			ch_v_q    <= 1'b0;
			ch_q      <= '0;
			ch_err_q  <= 1'b0;
			sil_q     <= '0;
		end else begin
			rc_busy_q <= rc_busy_d;
			rc_cnt_q  <= rc_cnt_d;
			rc_idx_q  <= rc_idx_d;
			rc_sh_q   <= rc_sh_d;
			ch_v_q    <= ch_v_d;
			ch_q      <= ch_d;
			ch_err_q  <= ch_err_d;
			sil_q     <= sil_d;
		end
	end

	// Silence limits; fast rates use fixed times so a short bit time
	// does not shrink the gap below what slow peers can honour.
	assign fast    = div_q < FAST_DIV_LIMIT;
	assign t15     = fast ? 40'(GAP_CYC) :
	                 40'((32'(div_q) * GAP_HALF_BITS) >> 1);
	assign t35     = fast ? 40'(SIL_CYC) :
	                 40'((32'(div_q) * SIL_HALF_BITS) >> 1);
	assign tmo_lim = 40'((tmo_q == 8'h0) ? 8'h1 : tmo_q) * 40'(TMO_CYC);
	assign hv      = (ch_q >= 8'h30 && ch_q <= 8'h39) ? {1'b1, ch_q[3:0]} :
	                 (ch_q >= 8'h41 && ch_q <= 8'h46) ?
	                 {1'b1, ch_q[3:0] + 4'h9} : 5'h00;

	// ----------------------------------------------------------------
	// Link state, frame reception and transmission
	// ----------------------------------------------------------------
	always_comb begin
		ln_d = ln_q;       tp_d = tp_q;       len_d = len_q;
		crc_d = crc_q;     lrc_d = lrc_q;     nib_d = nib_q;
		half_d = half_q;   cr_d = cr_q;       bad_d = bad_q;
		skip_d = skip_q;   adr_d = adr_q;     gap_d = gap_q;
		tidx_d = tidx_q;   rxlen_d = rxlen_q; tx_sh_d = tx_sh_q;
		tx_n_d = tx_n_q;   tx_cnt_d = tx_cnt_q;
		tx_busy_d = tx_busy_q;
		oe_n_d  = (ln_q != LN_TX);
		st_set  = '0;
		tx_take = 1'b0;
		rx_open = 1'b0;
		byte_v  = 1'b0;
		byte_b  = ch_q;
		fin     = 1'b0;
		chk_ok  = 1'b0;
		tgo     = 1'b0;
		tchr    = 8'hFF;
		tb      = tx_mem[tidx_q[7:0]];
		ck      = ~lrc_q + 8'h01;
		rx_we   = 1'b0;
		rx_wd   = byte_b;
		// Bit timer of the transmitter; the line idles at one.
		if (tx_busy_q) begin
			if (tx_cnt_q == 16'h0) begin
				tx_sh_d  = {1'b1, tx_sh_q[10:1]};
				tx_cnt_d = div_q - 16'h1;
				tx_n_d   = tx_n_q - 4'h1;
				if (tx_n_q == 4'h1) tx_busy_d = 1'b0;
			end else begin
				tx_cnt_d = tx_cnt_q - 16'h1;
			end
		end
		case (ln_q)
		LN_INIT: begin
			if (cfg_q.text || sil_q >= t35) ln_d = LN_IDLE;
		end
		LN_IDLE: begin
			if (tx_req_q) begin
				ln_d    = LN_TX;
				tx_take = 1'b1;
				tidx_d  = '0;
				half_d  = 1'b0;
				crc_d   = CRC_INIT;
				lrc_d   = 8'h00;
				tp_d    = cfg_q.text ? TP_SOF :
				          ((txlen_q == 9'h0) ? TP_CK0 : TP_DATA);
			end else if (ch_v_q && !cfg_q.text) begin
				rx_open = 1'b1;
				byte_v  = 1'b1;
			end else if (ch_v_q && ch_q == CH_COLON) begin
				rx_open = 1'b1;
			end
		end
		LN_RX: begin
			if (!cfg_q.text) begin
				if (ch_v_q) begin
					byte_v = 1'b1;
					gap_d  = 1'b0;
					if (gap_q) bad_d = 1'b1;
				end else if (sil_q >= t35) begin
					fin    = 1'b1;
					chk_ok = (crc_q == 16'h0000);
					if (len_q < BIN_MIN_LEN) bad_d = 1'b1;
				end else if (sil_q > t15) begin
					gap_d = 1'b1;
				end
			end else if (ch_v_q) begin
				if (ch_q == CH_COLON) begin
					st_set[ST_INCOMPL] = 1'b1;
					rx_open            = 1'b1;
				end else if (cr_q) begin
					if (ch_q == lf_q) begin
						fin    = 1'b1;
						chk_ok = (lrc_q == 8'h00) && !half_q;
						if (len_q < TXT_MIN_LEN || half_q) bad_d = 1'b1;
					end else begin
						st_set[ST_INCOMPL] = 1'b1;
						ln_d               = LN_IDLE;
					end
				end else if (ch_q == CH_CR) begin
					cr_d = 1'b1;
				end else if (hv[4]) begin
					half_d = ~half_q;
					nib_d  = hv[3:0];
					byte_b = {nib_q, hv[3:0]};
					byte_v = half_q;
				end else begin
					bad_d = 1'b1;
				end
			end else if (sil_q > tmo_lim) begin
				st_set[ST_TIMEOUT] = 1'b1;
				ln_d               = LN_IDLE;
			end
			if (ch_v_q && ch_err_q) begin
				st_set[ST_CHAR_ERR] = 1'b1;
				bad_d               = 1'b1;
			end
		end
		LN_TX: begin
			if (!tx_busy_q) begin
				tgo = 1'b1;
				case (tp_q)
				TP_SOF: begin
					tchr = CH_COLON;
					tp_d = (txlen_q == 9'h0) ? TP_CK0 : TP_DATA;
				end
				TP_DATA: begin
					if (cfg_q.text) begin
						tchr   = hex_char(half_q ? tb[3:0] : tb[7:4]);
						half_d = ~half_q;
					end else begin
						tchr  = tb;
						crc_d = crc_step(crc_q, tb);
					end
					if (half_q || !cfg_q.text) begin
						lrc_d  = lrc_q + tb;
						tidx_d = tidx_q + 9'h1;
						if (tidx_d == txlen_q) tp_d = TP_CK0;
					end
				end
				TP_CK0: begin
					if (cfg_q.text) begin
						tchr   = hex_char(half_q ? ck[3:0] : ck[7:4]);
						half_d = ~half_q;
						if (half_q) tp_d = TP_CR;
					end else begin
						tchr = crc_q[7:0];
						tp_d = TP_CK1;
					end
				end
				TP_CK1: begin
					tchr = crc_q[15:8];
					tp_d = TP_END;
				end
				TP_CR: begin
					tchr = CH_CR;
					tp_d = TP_LF;
				end
				TP_LF: begin
					tchr = lf_q;
					tp_d = TP_END;
				end
				default: begin
					tgo                = 1'b0;
					st_set[ST_TX_DONE] = 1'b1;
					// Binary mode must keep the line quiet before reuse.
					ln_d = cfg_q.text ? LN_IDLE : LN_INIT;
				end
				endcase
				if (tgo) begin
					tx_sh_d   = tx_frame(tchr, cfg_q.text, cfg_q.par);
					tx_n_d    = cfg_q.text ? CHAR_BITS_TXT : CHAR_BITS_BIN;
					tx_cnt_d  = div_q - 16'h1;
					tx_busy_d = 1'b1;
				end
			end
		end
		default: ln_d = LN_INIT;
		endcase
		// Open a fresh receive buffer.
		if (rx_open) begin
			ln_d  = LN_RX;
			len_d = '0;
			crc_d = CRC_INIT;
			lrc_d = 8'h00;
			{half_d, cr_d, bad_d, skip_d, gap_d} = 5'b00000;
			if (ch_err_q) begin
				st_set[ST_CHAR_ERR] = 1'b1;
				bad_d               = 1'b1;
			end
		end
		// Take one decoded byte into the buffer and the checks.
		if (byte_v) begin
			if (len_d == 9'h0) begin
				adr_d = byte_b;
				if (cfg_q.early && !mine(byte_b)) skip_d = 1'b1;
			end
			if (len_d == RX_MAX_LEN) begin
				bad_d = 1'b1;
			end else begin
				len_d = len_d + 9'h1;
				rx_we = !skip_d;
				rx_wd = byte_b;
				if (!skip_d) begin
					crc_d = crc_step(crc_d, byte_b);
					lrc_d = lrc_d + byte_b;
				end
			end
		end
		// Check value first, then the address.
		if (fin) begin
			ln_d = LN_IDLE;
			if (bad_d)         st_set[ST_INCOMPL]  = 1'b1;
			else if (skip_q)   st_set[ST_DROPPED]  = 1'b1;
			else if (!chk_ok)  st_set[ST_CHECK_ERR] = 1'b1;
			else if (!mine(adr_q)) st_set[ST_DROPPED] = 1'b1;
			else begin
				st_set[ST_FRAME_OK] = 1'b1;
				rxlen_d             = len_q;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ln_q <= LN_INIT;   tp_q <= TP_END;   len_q <= '0;
			crc_q <= CRC_INIT; lrc_q <= '0;      nib_q <= '0;
			half_q <= 1'b0;    cr_q <= 1'b0;     bad_q <= 1'b0;
			skip_q <= 1'b0;    adr_q <= '0;      gap_q <= 1'b0;
			tidx_q <= '0;      rxlen_q <= '0;    tx_sh_q <= '1;
			tx_n_q <= '0;      tx_cnt_q <= '0;   tx_busy_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			ln_q <= ln_d;      tp_q <= tp_d;     len_q <= len_d;
			crc_q <= crc_d;    lrc_q <= lrc_d;   nib_q <= nib_d;
			half_q <= half_d;  cr_q <= cr_d;     bad_q <= bad_d;
			skip_q <= skip_d;  adr_q <= adr_d;   gap_q <= gap_d;
			tidx_q <= tidx_d;  rxlen_q <= rxlen_d; tx_sh_q <= tx_sh_d;
			tx_n_q <= tx_n_d;  tx_cnt_q <= tx_cnt_d;
			tx_busy_q <= tx_busy_d;
			oe_n_q <= oe_n_d;
		end
	end

	// Frame buffers; the receive index is taken before the increment.
	always_ff @(posedge clk_sys) begin
		if (rx_we) rx_mem[rx_open ? 8'h00 : len_q[7:0]] <= rx_wd;
		if (wr_ok && avs_address[11:10] == WIN_TX_BUF) begin
			tx_mem[avs_address[9:2]] <= avs_writedata[7:0];
		end
	end

	assign line_o    = tx_sh_q[0];
	assign line_oe_n = oe_n_q;

	// ----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle for every access
	// ----------------------------------------------------------------
	assign req             = avs_read || avs_write;
	assign avs_waitrequest = req && !ack_q;
	assign wr_ok           = avs_write && ack_q;
	assign rd_go           = avs_read && !ack_q;
	assign avs_readdata    = rdata_q;

	always_comb begin
		ack_d   = req && !ack_q;
		cfg_d   = cfg_q;  own_d = own_q;  div_d = div_q;
		lf_d    = lf_q;   tmo_d = tmo_q;  txlen_d = txlen_q;
		rdata_d = rdata_q;
		// Hardware events win over a clear in the same cycle.
		stat_d   = stat_q | st_set;
		tx_req_d = (tx_req_q && !tx_take);
		if (wr_ok && avs_address[11:10] == WIN_REGS) begin
			case (avs_address)
			REG_CTRL:     cfg_d = srf_cfg_t'(avs_writedata[3:0]);
			REG_OWN_ADDR: own_d = avs_writedata[7:0];
			REG_BAUD_DIV: div_d = avs_writedata[15:0];
			REG_LF_CHAR:  lf_d  = avs_writedata[7:0];
			REG_TMO_SEC:  tmo_d = avs_writedata[7:0];
			REG_STATUS:   stat_d = (stat_q & ~avs_writedata[6:0]) | st_set;
			REG_TX_LEN:   txlen_d = (avs_writedata[8:0] > TX_MAX_LEN) ?
			                        TX_MAX_LEN : avs_writedata[8:0];
			REG_CMD:      tx_req_d = tx_req_d || avs_writedata[CMD_SEND];
			default:      ;
			endcase
		end
		if (rd_go) begin
			rdata_d = '0;
			if (avs_address[11:10] == WIN_RX_BUF) begin
				rdata_d = {24'h0, rx_mem[avs_address[9:2]]};
			end else if (avs_address[11:10] == WIN_REGS) begin
				case (avs_address)
				REG_CTRL:     rdata_d = {28'h0, cfg_q};
				REG_OWN_ADDR: rdata_d = {24'h0, own_q};
				REG_BAUD_DIV: rdata_d = {16'h0, div_q};
				REG_LF_CHAR:  rdata_d = {24'h0, lf_q};
				REG_TMO_SEC:  rdata_d = {24'h0, tmo_q};
				REG_STATUS:   rdata_d = {20'h0, tx_req_q, ln_q == LN_TX,
				                         ln_q == LN_RX, ln_q == LN_IDLE,
				                         1'b0, stat_q};
				REG_TX_LEN:   rdata_d = {23'h0, txlen_q};
				REG_RX_LEN:   rdata_d = {23'h0, rxlen_q};
				default:      rdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;     cfg_q <= CFG_RST;  own_q <= OWN_ADDR_RST;
			div_q <= DIV_RST;  lf_q <= LF_RST;    tmo_q <= TMO_RST;
			txlen_q <= '0;     stat_q <= '0;      tx_req_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q <= ack_d;    cfg_q <= cfg_d;    own_q <= own_d;
			div_q <= div_d;    lf_q <= lf_d;      tmo_q <= tmo_d;
			txlen_q <= txlen_d; stat_q <= stat_d; tx_req_q <= tx_req_d;
			rdata_q <= rdata_d;
		end
	end

endmodule : srf_framer

`default_nettype wire

// *** testbench/srf_framer_properties.sv ***
// Purpose: Port assertions for the serial frame engine.
// Assumes: The bench programs 8 clocks per serial bit.
// Notes:   Bit-time repetitions follow that setting.
`timescale 1ns/1ns
`default_nettype none
module srf_props (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [11:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        line_o,
	input wire logic        line_oe_n
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic req = avs_read | avs_write;
	// Bus answers after exactly one wait cycle.
	a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
		else $error("no wait cycle at access start");
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait cycle too long");
	a_wait_none: assert property (!req |-> !avs_waitrequest)
		else $error("wait without a request");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest
		&& avs_address == 12'h024 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Serial line shape; a bit shorter than eight clocks shows at once here.
	a_idle_high: assert property (line_oe_n |-> line_o)
		else $error("line low while not driving");
	a_start_len: assert property ($fell(line_o) |->
		(!line_oe_n && !line_o) [*8])
		else $error("bad start bit");
	a_bit_stable: assert property ($changed(line_o) |=>
		$stable(line_o) [*7])
		else $error("bit shorter than eight clocks");
	a_gap_after: assert property ($rose(line_oe_n) |=>
		line_oe_n [*8])
		else $error("send restarted without silence");
	c_tx: cover property ($fell(line_oe_n));
	c_rd: cover property (avs_read && !avs_waitrequest);
	c_wr: cover property (avs_write && !avs_waitrequest);
endmodule : srf_props
bind srf_framer srf_props u_props (.clk_sys(clk_sys), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .line_o(line_o),
	.line_oe_n(line_oe_n));
`default_nettype wire

// *** testbench/srf_peer.sv ***
// Purpose: Peer node on the serial line, binary characters.
// Assumes: 8 clocks per bit, even parity.
// Notes:   The idle line rests high as on a biased bus.
`timescale 1ns/1ns
`default_nettype none
module srf_peer (
	input  wire logic clk_sys,
	input  wire logic line_o,
	output var  logic line_i
);
	logic [7:0] rxq [$];
	logic       perr;
	logic [9:0] sh;
	initial begin
		line_i = 1'b1;
		perr = 1'b0;
	end
	// Start, eight data bits LSB first, even parity, stop.
	task automatic send(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ^b, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_i <= f[i];
			repeat (8) @(posedge clk_sys);
		end
	endtask : send
	// Collect what the block sends, sampling near mid-bit.
	initial forever begin
		@(posedge clk_sys iff line_o === 1'b0);
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			repeat (8) @(posedge clk_sys);
			sh[i] = line_o;
		end
		rxq.push_back(sh[7:0]);
		perr |= ^sh[8:0] | !sh[9];
	end
endmodule : srf_peer
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the serial frame engine.
// Assumes: Short timers; 8 clocks per bit once programmed.
// Notes:   Frames come from the peer model.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import srf_pkg::*;
	logic        clk_sys, rst, avs_read, avs_write, line_i, line_o;
	logic        line_oe_n, avs_waitrequest;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] c;
	int          n_errors = 0, comparisons = 0;
	logic [11:0] ra [5] = '{REG_CTRL, REG_OWN_ADDR, REG_BAUD_DIV,
		REG_LF_CHAR, 12'h024};
	logic [31:0] rv [5] = '{32'h0, 32'(OWN_ADDR_RST), 32'(DIV_RST),
		32'(LF_RST), 32'h0};
	logic [7:0]  fa [5] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00};
	int          fg [5] = '{0, 0, 0, 300, 0};
	logic        fb [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [6:0]  fm [5] = '{7'h7F, 7'h7F, 7'h43, 7'h09, 7'h7F};
	logic [6:0]  fe [5] = '{7'h01, 7'h02, 7'h40, 7'h08, 7'h01};
	logic [7:0]  te [4];
	srf_framer #(.GAP_CYC(200), .SIL_CYC(400), .TMO_CYC(2000)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .line_i(line_i),
		.line_o(line_o), .line_oe_n(line_oe_n));
	srf_peer u_peer (.clk_sys(clk_sys), .line_o(line_o), .line_i(line_i));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] crc(input logic [15:0] r,
		input logic [7:0] b);
		r ^= {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		return r;
	endfunction : crc
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// Request held until waitrequest is seen low at an edge.
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		{avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		r = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
	endtask : bus
	task automatic frame(input logic [7:0] a, input int g, input logic bad);
		c = crc(crc(16'hFFFF, a), 8'h03);
		u_peer.send(a);
		repeat (g) @(posedge clk_sys);
		u_peer.send(8'h03);
		u_peer.send(c[7:0] ^ {7'h00, bad});
		u_peer.send(c[15:8]);
		repeat (600) @(posedge clk_sys);
	endtask : frame
	// Hang guard, well beyond the length of the run.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], 32'h0, q);
			chk("reset value", q, rv[i]);
		end
		bus(1'b0, REG_STATUS, 32'h0, q);
		chk("idle early", 32'(q[8]), 32'h0);
		bus(1'b1, REG_BAUD_DIV, 32'h8, q);
		repeat (500) @(posedge clk_sys);
		bus(1'b0, REG_STATUS, 32'h0, q);
		chk("idle late", 32'(q[8]), 32'h1);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, REG_CTRL, 32'(fb[i]) << 3, q);
			bus(1'b1, REG_STATUS, 32'h7F, q);
			frame(fa[i], fg[i], fb[i]);
			bus(1'b0, REG_STATUS, 32'h0, q);
			chk("rx status", 32'(q[6:0] & fm[i]), 32'(fe[i]));
		end
		bus(1'b0, REG_RX_LEN, 32'h0, q);
		chk("rx length", q, 32'h4);
		bus(1'b0, 12'h400, 32'h0, q);
		chk("rx byte", q, 32'h0);
		bus(1'b1, 12'h800, 32'h11, q);
		bus(1'b1, 12'h804, 32'h22, q);
		bus(1'b1, REG_TX_LEN, 32'h2, q);
		bus(1'b1, REG_CMD, 32'h1, q);
		repeat (800) @(posedge clk_sys);
		c = crc(crc(16'hFFFF, 8'h11), 8'h22);
		te = '{8'h11, 8'h22, c[7:0], c[15:8]};
		chk("tx count", 32'(u_peer.rxq.size()), 32'h4);
		for (int i = 0; i < 4 && i < u_peer.rxq.size(); i++)
			chk("tx byte", 32'(u_peer.rxq[i]), 32'(te[i]));
		chk("tx parity", 32'(u_peer.perr), 32'h0);
		bus(1'b0, REG_STATUS, 32'h0, q);
		chk("tx done", 32'(q[5]), 32'h1);
		summarize();
	end
endmodule : tb
`default_nettype wire
